// File: src/xpt_config_ctrl.sv
// Purpose: Configuration control of a four-by-four crosspoint switch
// Assumes: load, mode and serial data change with the control clock, from the same host
// Notes:   Link logic runs on controlClk, everything else on core_clk
// Function
// - each output has its own 4:1 selector
// - mode low serial, mode high direct select
// - serial mode shifts data on control clock
// - load high at clock edge commits staged routing
// - load rising edge applies last valid frame
// - cascade data forwarded with address decremented
// - cascade clocks copy control clock in serial
// - mode high isolates clock, cascade clocks low
// - direct select updates routing without load
// - codes 00 and 01 broadcast input one/two
// - code 10 splits inputs one and three
// - code 11 routes each input straight through
// - serial mode ignores select pins for routing
`timescale 1ns/1ns
module xpt_config_ctrl
    import xpt_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             resetn,
    // Register port
    input  wire logic [xpt_cfg_pkg::REG_AW-1:0]   regAddr,
    input  wire logic [xpt_cfg_pkg::REG_DW-1:0]   regWdata,
    input  wire logic                             regWrite,
    input  wire logic                             regRead,
    output logic      [xpt_cfg_pkg::REG_DW-1:0]   regRdata,
    // Serial control and select pins
    input  wire logic                             controlClk,
    input  wire logic                             selectHighBit,
    input  wire logic                             selectLowBit,
    input  wire logic                             load,
    input  wire logic                             mode,
    // Cascade outputs
    output logic                                  columnCascadeData,
    output logic                                  rowCascadeData,
    output logic                                  columnCascadeClock,
    output logic                                  rowCascadeClock,
    // Switched lanes
    input  wire logic [xpt_cfg_pkg::NUM_PORTS-1:0] ingressPair,
    output logic      [xpt_cfg_pkg::NUM_PORTS-1:0] egressPair
);

    import xpt_cfg_pkg::*;

    // ---------------- Link domain (controlClk) ----------------

    logic [1:0]             linkRstSync_r;
    logic                   linkRstn;
    logic [FRAME_W-1:0]     shiftReg_r;
    logic [CNT_W-1:0]       bitCount_r;
    logic [FRAME_W-1:0]     colShift_r;
    logic [FRAME_W-1:0]     rowShift_r;
    route_type              stagedRoute_r;
    logic                   stagedTog_r;
    logic                   loadTog_r;
    logic                   linkShift;
    logic                   frameDone;
    logic                   frameHere;
    logic [FRAME_W-1:0]     frameWord;
    logic [ADDR_W-1:0]      frameRow;
    logic [ADDR_W-1:0]      frameCol;

    // Reset brought into the link domain through two flops
    always_ff @(posedge controlClk) begin
        linkRstSync_r <= {linkRstSync_r[0], resetn};
    end
    assign linkRstn = linkRstSync_r[1];

    // Shift only with load and mode low; mode high leaves the link idle
    assign linkShift = !load && !mode;
    assign frameWord = {shiftReg_r[FRAME_W-2:0], selectHighBit};
    assign frameDone = linkShift && (bitCount_r == FRAME_LAST);
    assign frameRow  = frameWord[ROW_LSB +: ADDR_W];
    assign frameCol  = frameWord[COL_LSB +: ADDR_W];
    assign frameHere = (frameRow == ADDR_ZERO) && (frameCol == ADDR_ZERO);

    // Input shift register, serial data enters at bit zero
    always_ff @(posedge controlClk) begin
        if (!linkRstn) begin
            shiftReg_r <= '0;
        end else if (linkShift) begin
            shiftReg_r <= frameWord;
        end
    end

    // Bit position within the current frame
    always_ff @(posedge controlClk) begin
        if (!linkRstn) begin
            bitCount_r <= '0;
        end else if (linkShift) begin
            bitCount_r <= CNT_W'(bitCount_r + 1'b1);
        end
    end

    // Load register: selects of the last frame addressed to this device
    always_ff @(posedge controlClk) begin
        if (!linkRstn) begin
            stagedRoute_r <= ROUTE_RESET;
            stagedTog_r   <= 1'b0;
        end else if (frameDone && frameHere) begin
            stagedRoute_r <= frameWord[SEL_LSB +: ROUTE_W];
            stagedTog_r   <= ~stagedTog_r;
        end
    end

    // Load seen on a control-clock edge, passed to the core as a toggle
    always_ff @(posedge controlClk) begin
        if (!linkRstn) begin
            loadTog_r <= 1'b0;
        end else if (load && !mode) begin
            loadTog_r <= ~loadTog_r;
        end
    end

    // Cascade shifters: reload with decremented address, else shift out MSB first
    always_ff @(posedge controlClk) begin
        if (!linkRstn) begin
            colShift_r <= '0;
            rowShift_r <= '0;
        end else if (frameDone) begin
            colShift_r <= {frameRow, ADDR_W'(frameCol - ADDR_ONE), frameWord[SEL_LSB +: ROUTE_W]};
            rowShift_r <= {ADDR_W'(frameRow - ADDR_ONE), frameCol, frameWord[SEL_LSB +: ROUTE_W]};
        end else if (linkShift) begin
            colShift_r <= {colShift_r[FRAME_W-2:0], 1'b0};
            rowShift_r <= {rowShift_r[FRAME_W-2:0], 1'b0};
        end
    end

    // Cascade data pins come straight from the shifter MSBs
    assign columnCascadeData = colShift_r[FRAME_W-1];
    assign rowCascadeData    = rowShift_r[FRAME_W-1];

    // ---------------- Core domain (core_clk) ----------------

    logic [1:0]             modeSync_r;
    logic [2:0]             loadSync_r;
    logic [1:0]             sclkSync_r;
    selCode_type            selMeta_r;
    selCode_type            selSync_r;
    logic [2:0]             stagedTogSync_r;
    logic [2:0]             loadTogSync_r;
    route_type              stagedCore_r;
    logic                   frameSeen_r;
    route_type              route_r;
    logic [LOADCNT_W-1:0]   loadCount_r;
    logic                   colClk_r;
    logic                   rowClk_r;
    logic [REG_DW-1:0]      regRdata_r;
    logic                   modeS;
    logic                   loadRise;
    logic                   stagedEvt;
    logic                   loadTogEvt;
    logic                   loadEvt;
    logic                   routeWrite;
    route_type              stagedNow;

    // Synchronisers for pins and link-domain toggles
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            modeSync_r      <= '0;
            loadSync_r      <= '0;
            sclkSync_r      <= '0;
            selMeta_r       <= '0;
            selSync_r       <= '0;
            stagedTogSync_r <= '0;
            loadTogSync_r   <= '0;
        end else begin
            modeSync_r      <= {modeSync_r[0], mode};
            loadSync_r      <= {loadSync_r[1:0], load};
            sclkSync_r      <= {sclkSync_r[0], controlClk};
            selMeta_r       <= {selectHighBit, selectLowBit};
            selSync_r       <= selMeta_r;
            stagedTogSync_r <= {stagedTogSync_r[1:0], stagedTog_r};
            loadTogSync_r   <= {loadTogSync_r[1:0], loadTog_r};
        end
    end

    // Decoded events, all read from second stage onward
    assign modeS      = modeSync_r[1];
    assign loadRise   = loadSync_r[1] && !loadSync_r[2];
    assign stagedEvt  = stagedTogSync_r[1] ^ stagedTogSync_r[2];
    assign loadTogEvt = loadTogSync_r[1] ^ loadTogSync_r[2];
    assign loadEvt    = (loadRise || loadTogEvt) && !modeS;
    assign routeWrite = regWrite && (regAddr == ROUTE_OFF) && !modeS;

    // Staged word is stable while its toggle crosses, so it may be taken here
    assign stagedNow = stagedEvt ? stagedRoute_r : stagedCore_r;

    // Core copy of the staged routing
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            stagedCore_r <= ROUTE_RESET;
            frameSeen_r  <= 1'b0;
        end else if (stagedEvt) begin
            stagedCore_r <= stagedRoute_r;
            frameSeen_r  <= 1'b1;
        end
    end

    // Active routing: direct decode in select mode, load or software write in serial mode
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            route_r <= ROUTE_RESET;
        end else if (modeS) begin
            route_r <= directRoute(selSync_r);
        end else if (loadEvt) begin
            route_r <= stagedNow;
        end else if (routeWrite) begin
            route_r <= regWdata[ROUTE_W-1:0];
        end
    end

    // Count of configuration loads in serial mode
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            loadCount_r <= '0;
        end else if (loadEvt) begin
            loadCount_r <= LOADCNT_W'(loadCount_r + 1'b1);
        end
    end

    // Buffered cascade clocks, held low in select mode
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            colClk_r <= 1'b0;
            rowClk_r <= 1'b0;
        end else begin
            colClk_r <= sclkSync_r[1] && !modeS;
            rowClk_r <= sclkSync_r[1] && !modeS;
        end
    end
    assign columnCascadeClock = colClk_r;
    assign rowCascadeClock    = rowClk_r;

    // Register read, data valid in the following cycle only
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            regRdata_r <= '0;
        end else begin
            regRdata_r <= '0;
            if (regRead) begin
                case (regAddr)
                    ROUTE_OFF:   regRdata_r[ROUTE_W-1:0] <= route_r;
                    STAGED_OFF:  regRdata_r[ROUTE_W-1:0] <= stagedCore_r;
                    STATUS_OFF: begin
                        regRdata_r[STAT_MODE_BIT]         <= modeS;
                        regRdata_r[STAT_SEL_LSB +: 2]     <= selSync_r;
                        regRdata_r[STAT_FRAME_BIT]        <= frameSeen_r;
                    end
                    LOADCNT_OFF: regRdata_r[LOADCNT_W-1:0] <= loadCount_r;
                    default:     regRdata_r <= '0;
                endcase
            end
        end
    end
    assign regRdata = regRdata_r;

    // Selector bank
    xpt_route_if xp ();
    assign xp.route   = route_r;
    assign xp.ingress = ingressPair;
    assign egressPair = xp.egress;

    xpt_selector uSel (
        .core_clk (core_clk),
        .resetn   (resetn),
        .xp       (xp)
    );

    // ---------------- Checks ----------------

    sequence loadRiseSeq;
        $rose(loadSync_r[1]) && !loadSync_r[2] && !modeS;
    endsequence

    sequence loadTogSeq;
        loadTogEvt && !modeS;
    endsequence

    sequence selectModeSeq;
        modeS [*2];
    endsequence

    a_load_rise_apply: assert property (
        @(posedge core_clk) disable iff (!resetn)
        loadRiseSeq |=> route_r == $past(stagedNow))
        else $error("load rising edge did not apply staged routing");

    a_sclk_load_copy: assert property (
        @(posedge core_clk) disable iff (!resetn)
        loadTogSeq |=> route_r == $past(stagedNow))
        else $error("load at control clock edge did not commit routing");

    a_direct_mode_route: assert property (
        @(posedge core_clk) disable iff (!resetn)
        modeS |=> route_r == directRoute($past(selSync_r)))
        else $error("select mode routing does not follow select pins");

    a_distribution_codes: assert property (
        @(posedge core_clk) disable iff (!resetn)
        modeS && selSync_r == SEL_DIST_IN2 ##1 modeS && selSync_r == SEL_DIST_IN1
        |=> route_r == ROUTE_DIST_IN1 && $past(route_r) == ROUTE_DIST_IN2)
        else $error("distribution codes routed wrongly");

    a_redundant_code: assert property (
        @(posedge core_clk) disable iff (!resetn)
        modeS && selSync_r == SEL_REDUNDANT |=> route_r == ROUTE_REDUNDANT)
        else $error("redundancy code routed wrongly");

    a_broadside_code: assert property (
        @(posedge core_clk) disable iff (!resetn)
        modeS && selSync_r == SEL_BROADSIDE |=> route_r == ROUTE_BROADSIDE)
        else $error("broadside code routed wrongly");

    a_serial_ignores_select: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !modeS && !loadEvt && !routeWrite && $changed(selSync_r) |=> $stable(route_r))
        else $error("select pins changed routing in serial mode");

    a_cascade_clock_copy: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !modeS |=> columnCascadeClock == $past(sclkSync_r[1]) && rowCascadeClock == columnCascadeClock)
        else $error("cascade clock is not a copy of the control clock");

    a_cascade_clock_low: assert property (
        @(posedge core_clk) disable iff (!resetn)
        selectModeSeq |-> !columnCascadeClock && !rowCascadeClock)
        else $error("cascade clock active in select mode");

    a_shift_in_bit: assert property (
        @(posedge controlClk) disable iff (!linkRstn)
        !load && !mode |=> shiftReg_r[0] == $past(selectHighBit) && shiftReg_r[FRAME_W-1:1] == $past(shiftReg_r[FRAME_W-2:0]))
        else $error("serial bit not shifted in");

    a_link_isolated: assert property (
        @(posedge controlClk) disable iff (!linkRstn)
        mode |=> $stable(shiftReg_r) && $stable(bitCount_r) && $stable(loadTog_r))
        else $error("link state moved in select mode");

    a_cascade_address_dec: assert property (
        @(posedge controlClk) disable iff (!linkRstn)
        frameDone |=> colShift_r[COL_LSB +: ADDR_W] == ADDR_W'($past(frameCol) - ADDR_ONE)
                      && rowShift_r[ROW_LSB +: ADDR_W] == ADDR_W'($past(frameRow) - ADDR_ONE)
                      && columnCascadeData == $past(frameRow[ADDR_W-1]))
        else $error("cascade frame address not decremented");

endmodule // xpt_config_ctrl

// File: inc/xpt_cfg_pkg.sv
// Purpose: Shared constants, types and decode for the crosspoint configuration control
// Assumes: Four outputs, four shared inputs, two-bit source index per output
// Notes:   Frame layout is row address, column address, then egress_pair_4..egress_pair_1 selects, MSB first
package xpt_cfg_pkg;

    // Switch geometry
    localparam int NUM_PORTS = 4;
    localparam int SRC_W     = 2;
    localparam int ROUTE_W   = NUM_PORTS * SRC_W;

    typedef logic [SRC_W-1:0]          src_type;
    typedef src_type [NUM_PORTS-1:0]   route_type;
    typedef logic [1:0]                selCode_type;

    // Serial frame layout
    localparam int FRAME_W = 16;
    localparam int ADDR_W  = 4;
    localparam int CNT_W   = 4;
    localparam int ROW_LSB = 12;
    localparam int COL_LSB = 8;
    localparam int SEL_LSB = 0;
    localparam logic [CNT_W-1:0]  FRAME_LAST = 4'hF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_ONE   = 4'h1;

    // Fixed routings of the direct select port, entry k is the source of output k
    localparam route_type ROUTE_DIST_IN1  = 8'h00;
    localparam route_type ROUTE_DIST_IN2  = 8'h55;
    localparam route_type ROUTE_REDUNDANT = 8'hA0;
    localparam route_type ROUTE_BROADSIDE = 8'hE4;
    localparam route_type ROUTE_RESET     = ROUTE_BROADSIDE;

    // Select codes, high bit then low bit
    localparam selCode_type SEL_DIST_IN1  = 2'h0;
    localparam selCode_type SEL_DIST_IN2  = 2'h1;
    localparam selCode_type SEL_REDUNDANT = 2'h2;
    localparam selCode_type SEL_BROADSIDE = 2'h3;

    // Register port
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam logic [REG_AW-1:0] ROUTE_OFF   = 8'h00;
    localparam logic [REG_AW-1:0] STAGED_OFF  = 8'h04;
    localparam logic [REG_AW-1:0] STATUS_OFF  = 8'h08;
    localparam logic [REG_AW-1:0] LOADCNT_OFF = 8'h0C;
    localparam int STAT_MODE_BIT  = 0;
    localparam int STAT_SEL_LSB   = 1;
    localparam int STAT_FRAME_BIT = 3;
    localparam int LOADCNT_W      = 8;

    // Decode of the two select pins into a routing
    function automatic route_type directRoute(input selCode_type sel);
        case (sel)
            SEL_DIST_IN1:  directRoute = ROUTE_DIST_IN1;
            SEL_DIST_IN2:  directRoute = ROUTE_DIST_IN2;
            SEL_REDUNDANT: directRoute = ROUTE_REDUNDANT;
            default:       directRoute = ROUTE_BROADSIDE;
        endcase
    endfunction

endpackage

// File: inc/xpt_route_if.sv
// Purpose: Carries routing and lane data between control and selector
// Assumes: route and egress on core_clk, ingress lanes asynchronous
// Notes:   ctrl side drives route and ingress, mux side drives egress
`timescale 1ns/1ns
interface xpt_route_if;
    xpt_cfg_pkg::route_type             route;
    logic [xpt_cfg_pkg::NUM_PORTS-1:0]  ingress;
    logic [xpt_cfg_pkg::NUM_PORTS-1:0]  egress;

    modport ctrl (output route, output ingress, input egress);
    modport mux  (input route, input ingress, output egress);
endinterface

// File: src/xpt_selector.sv
// Purpose: Four independent 4:1 selectors over the shared ingress lanes
// Assumes: Ingress lanes arrive asynchronously and are synchronised here
// Notes:   Each egress lane is a flip-flop fed by its own selector
`timescale 1ns/1ns
module xpt_selector
    import xpt_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  resetn,
    // Routing and lanes
    xpt_route_if.mux   xp
);

    logic [NUM_PORTS-1:0] ingMeta_r;
    logic [NUM_PORTS-1:0] ingSync_r;
    wire  logic [NUM_PORTS-1:0] egressNxt;

    // Two-stage synchroniser on the ingress lanes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ingMeta_r <= '0;
            ingSync_r <= '0;
        end else begin
            ingMeta_r <= xp.ingress;
            ingSync_r <= ingMeta_r;
        end
    end

    // One selector per output, any source to any output
    for (genvar k = 0; k < NUM_PORTS; k++) begin : gSel
        assign egressNxt[k] = ingSync_r[xp.route[k]];

        a_output_select_path: assert property (
            @(posedge core_clk) disable iff (!resetn)
            1'b1 |=> xp.egress[k] == $past(ingSync_r[xp.route[k]]))
            else $error("egress lane does not follow its selected source");
    end

    // Egress lanes registered together so one process owns the whole word
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            xp.egress <= '0;
        end else begin
            xp.egress <= egressNxt;
        end
    end

endmodule // xpt_selector

// File: verification/xpt_host_model.sv
// Purpose: Host model driving the serial control and select pins
// Assumes: Control clock period of 30 ns, parked low between bursts
// Notes:   Samples both cascade data lines after every rising edge
`timescale 1ns/1ns
module xpt_host_model (
    // Pins towards the switch
    output logic        controlClk,
    output logic        selectHighBit,
    output logic        selectLowBit,
    output logic        load,
    output logic        mode,
    // Cascade data from the switch
    input  wire logic   columnCascadeData,
    input  wire logic   rowCascadeData
);
    logic [15:0] colCap;
    logic [15:0] rowCap;

    // Idle levels at time zero
    initial begin
        controlClk    = 1'b0;
        selectHighBit = 1'b0;
        selectLowBit  = 1'b0;
        load          = 1'b0;
        mode          = 1'b0;
        colCap        = 16'h0000;
        rowCap        = 16'h0000;
    end

    // Burst of edges at 33 MHz, clock left low afterwards
    task automatic pulses(input int n);
        repeat (n) begin
            #15 controlClk = 1'b1;
            #14 colCap = {colCap[14:0], columnCascadeData};
            rowCap = {rowCap[14:0], rowCascadeData};
            #1 controlClk = 1'b0;
        end
    endtask

    // Frame goes out MSB first, data changed while clock is low
    task automatic sendFrame(input logic [15:0] frame);
        for (int i = 15; i >= 0; i--) begin
            selectHighBit = frame[i];
            pulses(1);
        end
    endtask

    // Load after a settling gap, with or without a clock edge
    task automatic loadEdge(input logic withClk);
        #60 load = 1'b1;
        if (withClk) pulses(1);
        else #30;
        load = 1'b0;
        #30;
    endtask

    // Mode and select levels
    task automatic setPins(input logic m, input logic hi, input logic lo);
        mode          = m;
        selectHighBit = hi;
        selectLowBit  = lo;
    endtask
endmodule // xpt_host_model

// File: verification/xpt_config_ctrl_tb.sv
// Purpose: Self-checking bench for the crosspoint configuration control
// Assumes: Host model supplies the control clock and pins
// Notes:   Reset stretched so the link domain sees four clock edges
`timescale 1ns/1ns
module xpt_config_ctrl_tb;
    import xpt_cfg_pkg::*;
    logic                 core_clk;
    logic                 resetn;
    logic [REG_AW-1:0]    regAddr;
    logic [REG_DW-1:0]    regWdata;
    logic                 regWrite;
    logic                 regRead;
    logic [REG_DW-1:0]    regRdata;
    logic                 controlClk, selectHighBit, selectLowBit, load, mode;
    logic                 columnCascadeData, rowCascadeData, columnCascadeClock, rowCascadeClock;
    logic [NUM_PORTS-1:0] ingressPair;
    logic [NUM_PORTS-1:0] egressPair;
    int                   error_cnt = 0;
    int                   num_checks = 0;
    int                   colClkCnt = 0;
    int                   rowClkCnt = 0;
    int                   snapC, snapR;
    logic [15:0]          expC, expR;
    // Rows: select code, ingress lanes, expected egress lanes
    logic [9:0]           rows [8] = '{10'b01_0010_1111, 10'b01_1101_0000, 10'b00_0001_1111,
        10'b00_1110_0000, 10'b10_0001_0011, 10'b10_0100_1100, 10'b11_1010_1010, 10'b11_0101_0101};

    xpt_config_ctrl u_xpt_config_ctrl (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .controlClk(controlClk), .selectHighBit(selectHighBit), .selectLowBit(selectLowBit),
        .load(load), .mode(mode), .columnCascadeData(columnCascadeData),
        .rowCascadeData(rowCascadeData), .columnCascadeClock(columnCascadeClock),
        .rowCascadeClock(rowCascadeClock), .ingressPair(ingressPair), .egressPair(egressPair));

    xpt_host_model u_xpt_host_model (.controlClk(controlClk), .selectHighBit(selectHighBit),
        .selectLowBit(selectLowBit), .load(load), .mode(mode),
        .columnCascadeData(columnCascadeData), .rowCascadeData(rowCascadeData));

    // Core clock and cascade clock edge counters
    always #4 core_clk = ~core_clk;
    always @(posedge columnCascadeClock) colClkCnt++;
    always @(posedge rowCascadeClock) rowClkCnt++;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Register read, data taken in the cycle after the strobe
    task automatic chkReg(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 check(name, regRdata, exp);
    endtask

    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    task automatic print_verdict;
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        waitc(30000);
        error_cnt++;
        print_verdict;
    end

    initial begin
        core_clk    = 1'b0;
        resetn      = 1'b0;
        regAddr     = 8'h00;
        regWdata    = 32'h0000_0000;
        regWrite    = 1'b0;
        regRead     = 1'b0;
        ingressPair = 4'h0;
        fork
            u_xpt_host_model.pulses(4);
            waitc(16);
        join
        check("read data in reset", regRdata, 32'h0000_0000);
        resetn <= 1'b1;
        // Two edges release the link reset without shifting a stray bit
        u_xpt_host_model.pulses(2);
        chkReg("route after reset", ROUTE_OFF, 32'h0000_00E4);
        // Direct select table
        for (int i = 0; i < 8; i++) begin
            u_xpt_host_model.setPins(1'b1, rows[i][9], rows[i][8]);
            @(posedge core_clk);
            ingressPair <= rows[i][7:4];
            waitc(10);
            check("direct egress", egressPair, rows[i][3:0]);
        end
        chkReg("status in direct mode", STATUS_OFF, 32'h0000_0007);
        // Control clock isolated while in direct mode
        snapC = colClkCnt + rowClkCnt;
        u_xpt_host_model.pulses(3);
        waitc(8);
        check("cascade clocks in direct mode", colClkCnt + rowClkCnt - snapC, 0);
        u_xpt_host_model.setPins(1'b0, 1'b0, 1'b0);
        waitc(8);
        u_xpt_host_model.setPins(1'b0, 1'b0, 1'b1);
        waitc(8);
        chkReg("route in serial mode", ROUTE_OFF, 32'h0000_00E4);
        // Addressed frame, committed only at load, here given with a clock edge
        snapC = colClkCnt;
        snapR = rowClkCnt;
        u_xpt_host_model.sendFrame(16'h001B);
        waitc(8);
        check("column clock edges", colClkCnt - snapC, 16);
        check("row clock edges", rowClkCnt - snapR, 16);
        chkReg("route before load", ROUTE_OFF, 32'h0000_00E4);
        u_xpt_host_model.loadEdge(1'b1);
        waitc(8);
        chkReg("route after load", ROUTE_OFF, 32'h0000_001B);
        ingressPair <= 4'b0101;
        waitc(10);
        check("serial egress", egressPair, 4'b1010);
        // Cascade data carries the previous frame with address less one
        u_xpt_host_model.sendFrame(16'h3255);
        u_xpt_host_model.sendFrame(16'h3255);
        expC = 16'h3255 - 16'h0100;
        expR = 16'h3255 - 16'h1000;
        check("column cascade", u_xpt_host_model.colCap, {expC[14:0], expC[15]});
        check("row cascade", u_xpt_host_model.rowCap, {expR[14:0], expR[15]});
        // Load pin edge alone applies the last addressed frame
        u_xpt_host_model.sendFrame(16'h0000);
        u_xpt_host_model.loadEdge(1'b0);
        waitc(8);
        chkReg("route after load pin", ROUTE_OFF, 32'h0000_0000);
        // Register access kinds
        regWr(STAGED_OFF, 32'h0000_00FF);
        chkReg("staged read only", STAGED_OFF, 32'h0000_0000);
        regWr(ROUTE_OFF, 32'h0000_005A);
        chkReg("route written", ROUTE_OFF, 32'h0000_005A);
        chkReg("unmapped read", 8'h10, 32'h0000_0000);
        print_verdict;
    end
endmodule // xpt_config_ctrl_tb
